// [design/ahb_reg_slave.v]
// ahb-lite slave front end: zero wait states, always okay
// assumes the owner supplies read data for the address phase address
`timescale 1ns/1ps

module ahb_reg_slave (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire        hready,
  input  wire [31:0] rd_data,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output wire        wr_en,
  output wire [7:0]  wr_addr
);

  // ****************
  // address phase capture
  // ****************
  reg [31:0] hrdata_q;
  reg        wr_en_q;
  reg [7:0]  wr_addr_q;
  reg        ready_q;
  wire       take = hsel & htrans[1] & hready;

  // read data is sampled at the address phase so it leaves a flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q  <= 32'h00000000;
      wr_en_q   <= 1'b0;
      wr_addr_q <= 8'h00;
      ready_q   <= 1'b0;
    end else begin
      ready_q   <= 1'b1;
      wr_en_q   <= take & hwrite;
      if (take) begin
        wr_addr_q <= haddr[7:0];
        if (!hwrite) begin
          hrdata_q <= rd_data;
        end
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = ready_q;
  assign hresp     = 1'b0;
  assign wr_en     = wr_en_q;
  assign wr_addr   = wr_addr_q;

endmodule // ahb_reg_slave

// [design/bit_sync.v]
// two-flop synchroniser, one per bit
// assumes slowly changing pin levels; no bus coherency across bits
`timescale 1ns/1ps

module bit_sync #(
  parameter W = 1
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  // ****************
  // synchroniser stages
  // ****************
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule // bit_sync

// [design/radio_link_watchdog_monitor.v]
// radio link watchdog receiver: learns one transmitter, supervises its telegrams,
// drives link, battery and sensor outputs and the status leds
// assumes the radio front end delivers decoded telegrams on hclk, one-cycle valid
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "link_watchdog_regs.vh"

// Function
// R01: transmitter sends presence telegram every 10 s
// R02: watchdog expiry lights led until next telegram
// R03: watchdog expiry drives link output low
// R04: link output high while link in order
// R05: battery output high above remaining limit
// R06: sensor one output low when actuated
// R07: sensor two output low when actuated
// R08: learn switch on-off starts 15 s learning
// R09: after learning show sensors, pulse led
// R10: adjust switch enables potentiometer timeout setting
// R11: clockwise raises time; led blink shows time
// R12: range switch off gives 0 to 1 s
// R13: range switch on gives 0 to 30 s
// R14: adjust off keeps time; range still applies
// R15: operator retries failed learning without interferers
// R16: strength led shows link quality grade
// R17: no telegram while learning faults after 15 s
// R18: accepted telegram flashes watchdog led 15 ms
// R19: strength blink 200 ms, six grades
// R20: each telegram compares battery against limit
// R21: only learned identity updates outputs, watchdog
module radio_link_watchdog_monitor #(
  parameter MS_CYCLES = `MS_CYCLES_DFLT
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        learn_switch,
  input  wire        adjust_enable_switch,
  input  wire        range_select_switch,
  input  wire [7:0]  pot_level,
  input  wire        rx_valid,
  input  wire [31:0] rx_id,
  input  wire        rx_sensor_one,
  input  wire        rx_sensor_two,
  input  wire [7:0]  rx_battery,
  input  wire [7:0]  rx_strength,
  output reg         link_watchdog_output,
  output reg         battery_limit_output,
  output reg         sensor_one_output,
  output reg         sensor_two_output,
  output reg         wd_led,
  output reg         limit_led,
  output reg         sensor_one_led,
  output reg         sensor_two_led,
  output reg         si_green_led,
  output reg         si_red_led
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_LEARN = 4'h2;
  localparam [3:0] ST_FAULT = 4'h4;
  localparam [3:0] ST_RUN   = 4'h8;

  // ****************************************************************
  // pin synchronisers and bus front end
  // ****************************************************************
  wire [10:0] pins_s;
  wire        learn_s  = pins_s[0];
  wire        adjust_s = pins_s[1];
  wire        range_s  = pins_s[2];
  wire [7:0]  pot_s    = pins_s[10:3];

  bit_sync #(.W(11)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({pot_level, range_select_switch, adjust_enable_switch, learn_switch}),
    .sync_out (pins_s)
  );

  reg  [31:0] rd_mux;
  wire        wr_en;
  wire [7:0]  wr_addr;

  // hsize is not checked: only whole-word accesses are issued
  ahb_reg_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .rd_data   (rd_mux),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [3:0]  state_q;
  reg [31:0] id_q;
  reg [7:0]  batt_limit_q;
  reg        sw_learn_q;
  reg        learn_prev_q;
  reg [7:0]  pot_hold_q;
  reg [15:0] wd_time_q;
  reg [31:0] presc_q;
  reg        tick_q;
  reg [15:0] wd_cnt_q;
  reg [15:0] learn_cnt_q;
  reg [4:0]  flash_cnt_q;
  reg [15:0] blink_cnt_q;
  reg        blink_q;
  reg [7:0]  si_cnt_q;
  reg        si_phase_q;
  reg [2:0]  grade_q;
  reg        link_ok_q;

  wire accept    = rx_valid & (rx_id == id_q) & (state_q == ST_RUN);    // [R21]
  wire learn_go  = (learn_prev_q & ~learn_s) | sw_learn_q;             // [R08]
  wire expired   = (wd_cnt_q >= wd_time_q);
  wire adjusting = adjust_s & (state_q == ST_RUN);

  // ****************************************************************
  // bus register access
  // ****************************************************************
  always @* begin
    case (haddr[7:0])
      `ADDR_STATUS:     rd_mux = {20'h00000, grade_q, sensor_two_output,
                                  sensor_one_output, battery_limit_output,
                                  link_watchdog_output, adjusting, state_q};
      `ADDR_LEARNED_ID: rd_mux = id_q;
      `ADDR_BATT_LIMIT: rd_mux = {24'h000000, batt_limit_q};
      `ADDR_CONTROL:    rd_mux = 32'h00000000;
      `ADDR_WD_TIME:    rd_mux = {16'h0000, wd_time_q};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      batt_limit_q <= `BATT_LIMIT_RST;
      sw_learn_q   <= 1'b0;
    end else begin
      sw_learn_q <= wr_en & (wr_addr == `ADDR_CONTROL) & hwdata[`CTRL_LEARN_BIT];
      if (wr_en && (wr_addr == `ADDR_BATT_LIMIT)) begin
        batt_limit_q <= hwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // millisecond tick and watchdog time
  // ****************************************************************
  // every timer counts whole milliseconds; a shortened MS_CYCLES speeds simulation
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= 32'h00000000;
      tick_q  <= 1'b0;
    end else begin
      tick_q <= (presc_q == MS_CYCLES - 1);
      if (presc_q == MS_CYCLES - 1) begin
        presc_q <= 32'h00000000;
      end else begin
        presc_q <= presc_q + 32'h00000001;
      end
    end
  end

  // full-width products; the quotient never exceeds 30000, so 16 bits hold it
  wire [31:0] wd_long  = ({24'h000000, pot_hold_q} * `WD_LONG_MS) / `POT_FULL;
  wire [31:0] wd_short = ({24'h000000, pot_hold_q} * `WD_SHORT_MS) / `POT_FULL;

  // only the knob position is held; the range switch keeps scaling it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pot_hold_q <= `POT_RST;
      wd_time_q  <= 16'h0000;
    end else begin
      if (adjust_s) begin
        pot_hold_q <= pot_s;                                            // [R10] [R14]
      end
      if (range_s) begin
        wd_time_q <= wd_long[15:0];                                     // [R13]
      end else begin
        wd_time_q <= wd_short[15:0];                                    // [R12] [R11]
      end
    end
  end

  // ****************************************************************
  // learn and run sequence
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q      <= ST_IDLE;
      id_q         <= 32'h00000000;
      learn_prev_q <= 1'b0;
      learn_cnt_q  <= 16'h0000;
    end else begin
      learn_prev_q <= learn_s;
      case (state_q)
        ST_IDLE, ST_FAULT, ST_RUN: begin
          if (learn_go) begin
            state_q     <= ST_LEARN;                                    // [R08]
            learn_cnt_q <= 16'h0000;
          end
        end
        ST_LEARN: begin
          // the first telegram heard is taken; nearby systems must be quiet
          if (rx_valid) begin
            id_q    <= rx_id;                                           // [R21]
            state_q <= ST_RUN;
          end else if (learn_cnt_q >= `LEARN_MS) begin
            state_q <= ST_FAULT;                                        // [R17]
          end else if (tick_q) begin
            learn_cnt_q <= learn_cnt_q + 16'h0001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // learning success counts as the first telegram of the taught transmitter
  wire first = (state_q == ST_LEARN) & rx_valid;
  wire hit   = accept | first;

  // ****************************************************************
  // watchdog and outputs
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_q             <= 16'h0000;
      link_ok_q            <= 1'b0;
      link_watchdog_output <= 1'b0;
      battery_limit_output <= 1'b0;
      sensor_one_output    <= 1'b1;
      sensor_two_output    <= 1'b1;
      grade_q              <= 3'h5;
    end else begin
      if (hit) begin
        wd_cnt_q          <= 16'h0000;
        link_ok_q         <= 1'b1;
        sensor_one_output <= ~rx_sensor_one;                            // [R06] [R09]
        sensor_two_output <= ~rx_sensor_two;                            // [R07] [R09]
        battery_limit_output <= (rx_battery > batt_limit_q);            // [R05] [R20]
        if (rx_strength >= `SI_T0) grade_q <= 3'h0;                     // [R16]
        else if (rx_strength >= `SI_T1) grade_q <= 3'h1;
        else if (rx_strength >= `SI_T2) grade_q <= 3'h2;
        else if (rx_strength >= `SI_T3) grade_q <= 3'h3;
        else if (rx_strength >= `SI_T4) grade_q <= 3'h4;
        else grade_q <= 3'h5;
      end else if (state_q != ST_RUN) begin
        link_ok_q <= 1'b0;
      end else if (expired) begin
        link_ok_q <= 1'b0;                                              // [R03]
      end else if (tick_q) begin
        wd_cnt_q <= wd_cnt_q + 16'h0001;
      end
      link_watchdog_output <= link_ok_q & ~expired & (state_q == ST_RUN);  // [R04] [R03]
    end
  end

  // ****************************************************************
  // watchdog led
  // ****************************************************************
  reg [15:0] blink_half;
  always @* begin
    case (state_q)
      ST_LEARN: blink_half = `LEARN_BLINK_MS;
      ST_RUN:   blink_half = (wd_time_q == 16'h0000) ? 16'h0001 : wd_time_q;  // [R11]
      default:  blink_half = `FAULT_BLINK_MS;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_q <= 16'h0000;
      blink_q     <= 1'b0;
      flash_cnt_q <= 5'h00;
      wd_led      <= 1'b0;
    end else begin
      if (tick_q) begin
        if (blink_cnt_q >= blink_half - 16'h0001) begin
          blink_cnt_q <= 16'h0000;
          blink_q     <= ~blink_q;
        end else begin
          blink_cnt_q <= blink_cnt_q + 16'h0001;
        end
      end
      // flash length is quantised to the millisecond tick
      if (hit) begin
        flash_cnt_q <= `FLASH_MS;                                       // [R18]
      end else if (tick_q && flash_cnt_q != 5'h00) begin
        flash_cnt_q <= flash_cnt_q - 5'h01;
      end
      if (state_q != ST_RUN) begin
        wd_led <= blink_q;
      end else if (adjusting) begin
        wd_led <= blink_q;                                              // [R11]
      end else begin
        wd_led <= expired | (flash_cnt_q != 5'h00);                     // [R02] [R09]
      end
    end
  end

  // ****************************************************************
  // status leds
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      si_cnt_q       <= 8'h00;
      si_phase_q     <= 1'b0;
      si_green_led   <= 1'b0;
      si_red_led     <= 1'b0;
      limit_led      <= 1'b0;
      sensor_one_led <= 1'b0;
      sensor_two_led <= 1'b0;
    end else begin
      if (tick_q) begin
        if (si_cnt_q >= `SI_BLINK_MS - 8'h01) begin
          si_cnt_q   <= 8'h00;
          si_phase_q <= ~si_phase_q;                                    // [R19]
        end else begin
          si_cnt_q <= si_cnt_q + 8'h01;
        end
      end
      // odd grades blink, even grades stay lit; orange is green plus red
      if (state_q != ST_RUN) begin
        si_green_led <= 1'b0;
        si_red_led   <= 1'b0;
      end else begin
        si_green_led <= (grade_q <= 3'h3) & (~grade_q[0] | si_phase_q);  // [R16] [R19]
        si_red_led   <= (grade_q >= 3'h2) & (~grade_q[0] | si_phase_q);  // [R19]
      end
      limit_led      <= battery_limit_output;                           // [R20]
      sensor_one_led <= sensor_one_output;
      sensor_two_led <= sensor_two_output;
    end
  end

endmodule // radio_link_watchdog_monitor

// [pkg/link_watchdog_regs.vh]
// constants for the radio link watchdog receiver: register map, fields, timing
// assumes a 200 MHz hclk and an 8-bit potentiometer level
`ifndef LINK_WATCHDOG_REGS_VH
`define LINK_WATCHDOG_REGS_VH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_MHZ           200
`define MS_CYCLES_DFLT    (`CLK_MHZ * 1000)
`define PRESENCE_MS       16'h2710
`define LEARN_MS          16'h3A98
`define FLASH_MS          5'h0F
`define SI_BLINK_MS       8'hC8
`define LEARN_BLINK_MS    16'h03E8
`define FAULT_BLINK_MS    16'h00FA
`define WD_SHORT_MS       32'h000003E8
`define WD_LONG_MS        32'h00007530
`define POT_FULL          32'h000000FF

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define ADDR_STATUS       8'h00
`define ADDR_LEARNED_ID   8'h04
`define ADDR_BATT_LIMIT   8'h08
`define ADDR_CONTROL      8'h0C
`define ADDR_WD_TIME      8'h10

// ****************************************************************
// fields and reset values
// ****************************************************************
`define CTRL_LEARN_BIT    0
`define BATT_LIMIT_RST    8'h10
`define POT_RST           8'h00

// signal strength thresholds, grade 0 best .. 5 critical
`define SI_T0             8'hC0
`define SI_T1             8'hA0
`define SI_T2             8'h80
`define SI_T3             8'h60
`define SI_T4             8'h40

`endif

// [verif/link_watchdog_sva.sv]
// checker for the radio link watchdog receiver, ports only
// assumes one hclk domain and the MS_CYCLES value of the bound instance
`timescale 1ns/1ps
module link_watchdog_sva #(
  parameter MS_CYCLES = 20
) (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire rx_valid,
  input wire rx_sensor_one,
  input wire link_watchdog_output,
  input wire battery_limit_output,
  input wire sensor_one_output,
  input wire limit_led,
  input wire wd_led
);
  // ****************
  // helper logic
  // ****************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  localparam int FLASH_LO = 14 * MS_CYCLES - 2;
  localparam int FLASH_HI = 15 * MS_CYCLES + 3;
  // lit run while link up; tick quantising gives slack
  reg [15:0] run_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) run_q <= 16'h0000;
    else run_q <= (wd_led && link_watchdog_output) ? run_q + 16'h0001 : 16'h0000;
  end
  // ****************
  // properties
  // ****************
  sequence s_led_steady;
    wd_led [*8];
  endsequence
  sequence s_taken;
    $past(rx_valid, 2);
  endsequence
  property p_bus_ready;
    $past(hresetn) |-> hreadyout && !hresp;
  endproperty
  property p_link_cause;
    $rose(link_watchdog_output) |-> s_taken;
  endproperty
  property p_loss_led;
    $fell(link_watchdog_output) |=> ##1 s_led_steady;
  endproperty
  property p_flash_start;
    $rose(link_watchdog_output) |=> ##1 s_led_steady;
  endproperty
  property p_flash_max;
    run_q <= FLASH_HI;
  endproperty
  property p_flash_min;
    $fell(wd_led) && link_watchdog_output |-> run_q >= FLASH_LO;
  endproperty
  property p_sensor;
    $changed(sensor_one_output) && link_watchdog_output |->
      $past(rx_valid) && sensor_one_output == !$past(rx_sensor_one);
  endproperty
  property p_battery;
    $changed(battery_limit_output) && link_watchdog_output |-> $past(rx_valid);
  endproperty
  property p_limit_led;
    $changed(battery_limit_output) && link_watchdog_output |=>
      limit_led == $past(battery_limit_output);
  endproperty
  a_bus_ready: assert property (p_bus_ready) else $error("bus not ready or not okay");
  a_link_cause: assert property (p_link_cause) else $error("link rose without telegram");
  a_loss_led: assert property (p_loss_led) else $error("led not steady after loss");
  a_flash_start: assert property (p_flash_start) else $error("no flash on telegram");
  a_flash_max: assert property (p_flash_max) else $error("flash too long");
  a_flash_min: assert property (p_flash_min) else $error("flash too short");
  a_sensor: assert property (p_sensor) else $error("sensor output wrong");
  a_battery: assert property (p_battery) else $error("battery output moved alone");
  a_limit_led: assert property (p_limit_led) else $error("limit led mismatch");
endmodule // link_watchdog_sva

bind radio_link_watchdog_monitor link_watchdog_sva #(.MS_CYCLES(MS_CYCLES)) sva_i (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .rx_valid(rx_valid), .rx_sensor_one(rx_sensor_one),
  .link_watchdog_output(link_watchdog_output), .battery_limit_output(battery_limit_output),
  .sensor_one_output(sensor_one_output), .limit_led(limit_led), .wd_led(wd_led));

// [verif/tb_radio_link_watchdog_monitor.sv]
// self-checking bench for the radio link watchdog receiver
// assumes zero-wait ahb slave and MS_CYCLES scaled down to 20
`timescale 1ns/1ps
`include "link_watchdog_regs.vh"
module tb_radio_link_watchdog_monitor;
  localparam MS = 20;
  localparam [31:0] ID_A = 32'h00A5C3E1;
  reg         hclk, hresetn, hsel, hwrite, learn_switch, adjust_enable_switch;
  reg         range_select_switch;
  reg  [31:0] haddr, hwdata, q;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [7:0]  pot_level;
  wire [31:0] hrdata, rx_id;
  wire [7:0]  rx_battery, rx_strength;
  wire        hreadyout, hresp, rx_valid, rx_sensor_one, rx_sensor_two;
  wire        link_watchdog_output, battery_limit_output, sensor_one_output;
  wire        sensor_two_output, wd_led, limit_led, sensor_one_led, sensor_two_led;
  wire        si_green_led, si_red_led;
  integer     errors, checked, g, n, gh, rh;
  transmitter_model tx (.hclk(hclk), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_sensor_one(rx_sensor_one), .rx_sensor_two(rx_sensor_two),
    .rx_battery(rx_battery), .rx_strength(rx_strength));
  radio_link_watchdog_monitor #(.MS_CYCLES(MS)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .learn_switch(learn_switch), .adjust_enable_switch(adjust_enable_switch),
    .range_select_switch(range_select_switch), .pot_level(pot_level), .rx_valid(rx_valid),
    .rx_id(rx_id), .rx_sensor_one(rx_sensor_one), .rx_sensor_two(rx_sensor_two),
    .rx_battery(rx_battery), .rx_strength(rx_strength),
    .link_watchdog_output(link_watchdog_output), .battery_limit_output(battery_limit_output),
    .sensor_one_output(sensor_one_output), .sensor_two_output(sensor_two_output),
    .wd_led(wd_led), .limit_led(limit_led), .sensor_one_led(sensor_one_led),
    .sensor_two_led(sensor_two_led), .si_green_led(si_green_led), .si_red_led(si_red_led));
  // ****************
  // shared tasks
  // ****************
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      hsel <= 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h00000000);
      chk(q, exp);
    end
  endtask
  // spacing clears each flash
  task tg(input [31:0] id, input s1, input s2, input [7:0] b, input [7:0] st);
    begin
      repeat (320) @(posedge hclk);
      tx.send(id, s1, s2, b, st);
      repeat (3) @(posedge hclk);
      #1;
    end
  endtask
  task adj(input e, input r, input [7:0] p, input [31:0] exp);
    begin
      @(posedge hclk);
      adjust_enable_switch <= e;
      range_select_switch <= r;
      pot_level <= p;
      repeat (10) @(posedge hclk);
      rchk(`ADDR_WD_TIME, exp);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task t_reset;
    begin
      chk(link_watchdog_output, 0);
      chk({battery_limit_output, sensor_one_output, sensor_two_output}, 3'h3);
      rchk(`ADDR_BATT_LIMIT, `BATT_LIMIT_RST);
      rchk(8'h20, 32'h00000000);
      bus(1'b0, `ADDR_STATUS, 32'h00000000);
      chk(q[3:0], 4'h1);
      $display("t_reset done");
    end
  endtask
  task t_adjust;
    begin
      adj(1'b1, 1'b0, 8'h33, 32'h000000C8);
      adj(1'b1, 1'b1, 8'h33, 32'h00001770);
      adj(1'b1, 1'b0, 8'hFF, 32'h000003E8);
      adj(1'b0, 1'b0, 8'hFF, 32'h000003E8);
      adj(1'b0, 1'b0, 8'h00, 32'h000003E8);
      $display("t_adjust done");
    end
  endtask
  task t_learn;
    begin
      @(posedge hclk);
      learn_switch <= 1'b1;
      repeat (5) @(posedge hclk);
      learn_switch <= 1'b0;
      repeat (6) @(posedge hclk);
      bus(1'b0, `ADDR_STATUS, 32'h00000000);
      chk(q[3:0], 4'h2);
      tg(ID_A, 1'b1, 1'b0, 8'h20, 8'hC0);
      chk(link_watchdog_output, 1);
      chk({sensor_one_output, sensor_two_output, battery_limit_output}, 3'h3);
      rchk(`ADDR_LEARNED_ID, ID_A);
      $display("t_learn done");
    end
  endtask
  task t_filter;
    begin
      tg(~ID_A, 1'b0, 1'b1, 8'h00, 8'hC0);
      chk({sensor_one_output, sensor_two_output, battery_limit_output}, 3'h3);
      tg(ID_A, 1'b0, 1'b1, 8'h10, 8'hC0);
      chk({sensor_one_output, sensor_two_output, battery_limit_output}, 3'h4);
      chk(limit_led, 0);
      bus(1'b1, `ADDR_BATT_LIMIT, 32'h00000005);
      rchk(`ADDR_BATT_LIMIT, 32'h00000005);
      tg(ID_A, 1'b0, 1'b1, 8'h10, 8'hC0);
      chk({battery_limit_output, limit_led}, 2'h3);
      $display("t_filter done");
    end
  endtask
  // odd grades blink: count lit cycles
  task t_grade;
    begin
      for (g = 0; g < 6; g = g + 1) begin
        tg(ID_A, 1'b0, 1'b0, 8'h20, 8'hC0 - 8'h20 * g[7:0]);
        n = g[0] ? 400 * MS : 20 * MS;
        gh = 0;
        rh = 0;
        repeat (n) begin
          @(posedge hclk);
          #1;
          gh = gh + si_green_led;
          rh = rh + si_red_led;
        end
        chk(g[0] && g < 4 ? (gh > n / 2 - 200 && gh < n / 2 + 200) : gh == (g < 4 ? n : 0), 1);
        chk(g[0] && g > 1 ? (rh > n / 2 - 200 && rh < n / 2 + 200) : rh == (g > 1 ? n : 0), 1);
      end
      $display("t_grade done");
    end
  endtask
  task t_expire;
    begin
      tg(ID_A, 1'b0, 1'b0, 8'h20, 8'hC0);
      n = 0;
      while (link_watchdog_output === 1'b1 && n < 25000) begin
        @(posedge hclk);
        #1;
        n = n + 1;
      end
      chk(n > 1000 * MS - 60 && n < 1000 * MS + 40, 1);
      chk(link_watchdog_output, 0);
      repeat (100) @(posedge hclk);
      #1;
      chk(wd_led, 1);
      tg(ID_A, 1'b0, 1'b0, 8'h20, 8'hC0);
      chk(link_watchdog_output, 1);
      $display("t_expire done");
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // ****************
  // clock, reset, sequence, watchdog
  // ****************
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    repeat (90000) @(posedge hclk);
    errors = errors + 1;
    test_done;
  end
  initial begin
    errors = 0;
    checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    learn_switch = 1'b0;
    adjust_enable_switch = 1'b0;
    range_select_switch = 1'b0;
    pot_level = 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_adjust;
    t_learn;
    t_filter;
    t_grade;
    t_expire;
    test_done;
  end
endmodule // tb_radio_link_watchdog_monitor

// [verif/transmitter_model.sv]
// remote two-sensor transmitter as seen through the radio front end
// assumes telegrams decoded on hclk; caller spaces them some 16 ms apart, far short of the 10 s presence period
`timescale 1ns/1ps
module transmitter_model (
  input wire       hclk,
  output reg        rx_valid = 1'b0,
  output reg [31:0] rx_id = 32'h00000000,
  output reg        rx_sensor_one = 1'b0,
  output reg        rx_sensor_two = 1'b0,
  output reg [7:0]  rx_battery = 8'h00,
  output reg [7:0]  rx_strength = 8'h00
);
  // one presence telegram; data lines show garbage once valid drops
  task send(input [31:0] id, input s1, input s2, input [7:0] b, input [7:0] st);
    begin
      @(posedge hclk);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_sensor_one <= s1;
      rx_sensor_two <= s2;
      rx_battery <= b;
      rx_strength <= st;
      @(posedge hclk);
      rx_valid <= 1'b0;
      rx_id <= ~id;
      rx_sensor_one <= ~s1;
      rx_sensor_two <= ~s2;
      rx_battery <= ~b;
      rx_strength <= ~st;
    end
  endtask
endmodule // transmitter_model
